// [hw/ass_fifo.sv]
`timescale 1ns/1ps
// ==========================================
// small synchronous fifo, valid/ready both sides
module ass_fifo #(
   parameter int W     = 16,
   parameter int DEPTH = 8
) (
   input  wire logic         mclk,
   input  wire logic         arst_n,
   input  wire logic         ce,
   input  wire logic [W-1:0] in_data,
   input  wire logic         in_valid,
   output logic              in_ready,
   output logic [W-1:0]      out_data,
   output logic              out_valid,
   input  wire logic         out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem [DEPTH];
   logic [AW:0]  wp_r;
   logic [AW:0]  rp_r;
   logic         push;
   logic         pop;

   assign in_ready  = (wp_r - rp_r) != (AW+1)'(DEPTH);
   assign out_valid = wp_r != rp_r;
   assign out_data  = mem[rp_r[AW-1:0]];
   assign push      = ce & in_valid & in_ready;
   assign pop       = ce & out_valid & out_ready;

   // storage
   always_ff @(posedge mclk) begin
      if (push) begin
         mem[wp_r[AW-1:0]] <= in_data;
      end
   end

   // pointers
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         wp_r <= '0;
         rp_r <= '0;
      end else begin
         if (push) begin
            wp_r <= wp_r + 1'b1;
         end
         if (pop) begin
            rp_r <= rp_r + 1'b1;
         end
      end
   end
endmodule

// [hw/ass_if.sv]
`timescale 1ns/1ps
// ==========================================
// four-wire serial link between master and sensor
interface ass_if;
   logic cs_n;
   logic sclk;
   logic mosi;
   logic miso;
   logic miso_oe;
   modport sensor (input cs_n, input sclk, input mosi, output miso, output miso_oe);
   modport master (output cs_n, output sclk, output mosi, input miso, input miso_oe);
endinterface

// [hw/ass_master.sv]
`timescale 1ns/1ps
// ==========================================
// master end: runs one frame per queued command word
module ass_master
   import ass_pkg::*;
#(
   parameter int DIV   = ASS_SCK_DIV,
   parameter int IDLE  = ASS_IDLE_REG_CYC,
   parameter int DEPTH = ASS_FIFO_DEPTH
) (
   input  wire logic                  mclk,
   input  wire logic                  arst_n,
   input  wire logic                  ce,
   ass_if.master                      lnk,
   input  wire logic [ASS_WORD_W-1:0] cmd_data,
   input  wire logic                  cmd_valid,
   output logic                       cmd_ready,
   input  wire logic                  cpol,
   input  wire logic                  want_parity,
   output logic [ASS_WORD_W-1:0]      rsp_data,
   output logic                       rsp_parity_ok,
   output logic                       rsp_valid
);
   typedef enum logic [3:0] {
      ASM_IDLE = 4'h1,
      ASM_LEAD = 4'h2,
      ASM_XFER = 4'h4,
      ASM_GAP  = 4'h8
   } ass_mst_state_t;

   logic [ASS_WORD_W-1:0] q_data;
   logic                  q_valid;
   logic                  q_ready;

   ass_fifo #(.W(ASS_WORD_W), .DEPTH(DEPTH)) u_fifo (
      .mclk      (mclk),
      .arst_n    (arst_n),
      .ce        (ce),
      .in_data   (cmd_data),
      .in_valid  (cmd_valid),
      .in_ready  (cmd_ready),
      .out_data  (q_data),
      .out_valid (q_valid),
      .out_ready (q_ready)
   );

   logic [1:0]  miso_s_r;
   ass_mst_state_t st_r;
   logic [15:0] cnt_r;
   logic [4:0]  nb_r;
   logic [ASS_WORD_W-1:0] tx_r;
   logic [ASS_WORD_W:0]   rx_r;
   logic        cs_r;
   logic        sck_r;
   logic        mosi_r;

   assign q_ready = ce & (st_r == ASM_IDLE);
   assign lnk.cs_n = cs_r;
   assign lnk.sclk = sck_r;
   assign lnk.mosi = mosi_r;

   // sensor output sampled through two flops
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         miso_s_r <= 2'h0;
      end else if (ce) begin
         miso_s_r <= {miso_s_r[0], lnk.miso};
      end
   end

   // frame sequencer: change mosi on fall, sample miso on rise
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         st_r      <= ASM_IDLE;
         cnt_r     <= '0;
         nb_r      <= '0;
         tx_r      <= '0;
         rx_r      <= '0;
         cs_r      <= 1'b1;
         sck_r     <= 1'b0;
         mosi_r    <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_data  <= '0;
         rsp_parity_ok <= 1'b0;
      end else if (ce) begin
         rsp_valid <= 1'b0;
         case (st_r)
            ASM_IDLE: begin
               sck_r <= cpol;
               if (q_valid) begin
                  tx_r   <= {q_data[ASS_WORD_W-2:0], 1'b0};
                  mosi_r <= q_data[ASS_WORD_W-1];
                  cs_r   <= 1'b0;
                  cnt_r  <= '0;
                  nb_r   <= '0;
                  st_r   <= ASM_LEAD;
               end
            end
            ASM_LEAD: begin
               cnt_r <= cnt_r + 16'h1;
               if (cnt_r == 16'(DIV - 1)) begin
                  cnt_r <= '0;
                  sck_r <= 1'b0;
                  st_r  <= ASM_XFER;
               end
            end
            ASM_XFER: begin
               cnt_r <= cnt_r + 16'h1;
               if (cnt_r == 16'(DIV - 1)) begin
                  cnt_r <= '0;
                  sck_r <= ~sck_r;
                  if (!sck_r) begin
                     rx_r <= {rx_r[ASS_WORD_W-1:0], miso_s_r[1]};
                     nb_r <= nb_r + 5'h01;
                  end else if (nb_r == (want_parity ? ASS_BITCNT_WORD + 5'h01
                                                     : ASS_BITCNT_WORD)) begin
                     sck_r <= cpol; // back to idle level with select
                     cs_r  <= 1'b1;
                     st_r  <= ASM_GAP;
                  end else begin
                     mosi_r <= tx_r[ASS_WORD_W-1];
                     tx_r   <= {tx_r[ASS_WORD_W-2:0], 1'b0};
                  end
               end
            end
            ASM_GAP: begin
               cnt_r <= cnt_r + 16'h1;
               if (cnt_r == 16'h0) begin
                  rsp_valid     <= 1'b1;
                  rsp_data      <= want_parity ? rx_r[ASS_WORD_W:1] : rx_r[ASS_WORD_W-1:0];
                  rsp_parity_ok <= want_parity ? ~^rx_r : 1'b1;
               end
               if (cnt_r == 16'(IDLE)) begin
                  sck_r <= cpol;
                  st_r  <= ASM_IDLE;
               end
            end
            default: begin
               st_r <= ASM_IDLE;
            end
         endcase
      end
   end
endmodule

// [hw/ass_pkg.sv]
package ass_pkg;
   // ==========================================
   // frame layout
   localparam int ASS_WORD_W     = 16;
   localparam int ASS_CMD_HI     = 15;
   localparam int ASS_CMD_LO     = 13;
   localparam int ASS_ADDR_HI    = 12;
   localparam int ASS_ADDR_LO    = 8;
   localparam int ASS_VAL_HI     = 7;
   localparam int ASS_REG_ZERO_LO = 0;
   localparam int ASS_REG_ZERO_HI = 1;
   localparam int ASS_REG_DIR     = 9;
   localparam int ASS_DIR_BIT     = 7;
   localparam int ASS_NREG       = 32;
   localparam logic [2:0] ASS_OP_READ  = 3'h2;
   localparam logic [2:0] ASS_OP_WRITE = 3'h4;
   localparam logic [4:0] ASS_BITCNT_CMD = 5'h08;
   localparam logic [4:0] ASS_BITCNT_WORD = 5'h10;
   // ==========================================
   // timing
   localparam int ASS_CLK_MHZ      = 200;
   localparam int ASS_REFRESH_NS   = 1000;
   localparam int ASS_REFRESH_CYC  = ASS_REFRESH_NS * ASS_CLK_MHZ / 1000;
   localparam int ASS_NVM_MS       = 20;
   localparam int ASS_NVM_CYC      = ASS_NVM_MS * 1000 * ASS_CLK_MHZ;
   localparam int ASS_IDLE_REG_NS  = 750;
   localparam int ASS_IDLE_REG_CYC = (ASS_IDLE_REG_NS * ASS_CLK_MHZ + 999) / 1000;
   localparam int ASS_SCK_DIV      = 8;
   // ==========================================
   // filter shift (tau as power of two samples)
   localparam int ASS_FILT_SH      = 3;
   localparam int ASS_FIFO_DEPTH   = 8;
endpackage

// [hw/ass_sensor.sv]
`timescale 1ns/1ps
// Functional notes
// - modes 0 and 3 both accepted, a clock fall before the first rise ignored
// - any clock rate up to 25MHz
// - sample rising, change falling, msb first
// - commands are exactly sixteen bits
// - seventeenth clock returns a parity bit
// - 150ns idle between angle frames
// - 750ns idle around register readout frames
// - wait 20ms before write readback
// - reload output buffer every microsecond
// - select low freezes buffer until release
// - angle shifted msb first over sixteen clocks
// - unused low bits padded with zeros
// - truncated frames accepted without error
// - fast reads repeat previous angle
// - read request opcode, address, zero byte
// - register value returned in upper byte
// - register writes persist, reload at start
// - direction and zero reference are programmable
// - angle passes lag-free second order filter
// - parity makes even count of ones
// - write request, readback acknowledges new value
// - early readback returns old register contents
module ass_sensor
   import ass_pkg::*;
#(
   parameter int RES_BITS = 14,
   parameter int NVM_CYC  = ASS_NVM_CYC
) (
   input  wire logic                  mclk,
   input  wire logic                  arst_n,
   input  wire logic                  ce,
   ass_if.sensor                      lnk,
   input  wire logic [ASS_WORD_W-1:0] fe_angle,
   input  wire logic                  fe_valid,
   output logic                       fe_ready,
   input  wire logic [7:0]            nvm_rd_data [ASS_NREG],
   output logic [ASS_WORD_W-1:0]      angle_out,
   output logic                       busy_nvm
);
   // ==========================================
   // pin synchronisers
   logic [1:0] cs_s_r;
   logic [1:0] sck_s_r;
   logic [1:0] mosi_s_r;
   logic       sck_d_r;
   logic       cs_d_r;

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cs_s_r   <= 2'h3;
         sck_s_r  <= 2'h0;
         mosi_s_r <= 2'h0;
         sck_d_r  <= 1'b0;
         cs_d_r   <= 1'b1;
      end else if (ce) begin
         cs_s_r   <= {cs_s_r[0], lnk.cs_n};
         sck_s_r  <= {sck_s_r[0], lnk.sclk};
         mosi_s_r <= {mosi_s_r[0], lnk.mosi};
         sck_d_r  <= sck_s_r[1];
         cs_d_r   <= cs_s_r[1];
      end
   end

   logic cs_l;
   logic sck;
   logic sck_rise;
   logic sck_fall;
   logic cs_fall;
   logic cs_rise;
   assign cs_l     = ~cs_s_r[1];
   assign sck      = sck_s_r[1];
   assign sck_rise = sck & ~sck_d_r; // no timeout, no lower rate limit
   assign sck_fall = ~sck & sck_d_r;
   assign cs_fall  = cs_d_r & ~cs_s_r[1];
   assign cs_rise  = ~cs_d_r & cs_s_r[1];

   // ==========================================
   // configuration registers, loaded from nvm at start
   logic [7:0] reg_r [ASS_NREG];
   logic       loaded_r;
   logic       wr_pend_r;
   logic [4:0] wr_addr_r;
   logic [7:0] wr_val_r;
   logic [31:0] nvm_cnt_r;

   function automatic logic par_even(input logic [ASS_WORD_W-1:0] w);
      par_even = ^w;
   endfunction

   function automatic logic [2:0] op_of(input logic [ASS_WORD_W-1:0] w);
      op_of = w[ASS_CMD_HI:ASS_CMD_LO];
   endfunction

   // ==========================================
   // angle path: filter, direction, zero, buffer
   logic [ASS_WORD_W+ASS_FILT_SH-1:0] f1_r;
   logic [ASS_WORD_W+ASS_FILT_SH-1:0] f2_r;
   logic [ASS_WORD_W-1:0]             filt;
   logic [ASS_WORD_W-1:0]             ang_adj;
   logic [ASS_WORD_W-1:0]             res_mask;
   logic [ASS_WORD_W-1:0]             buf_r;
   logic                              frozen_r;

   assign fe_ready = 1'b1;
   // lead term cancels the second pole lag at constant speed
   assign filt = ASS_WORD_W'((2 * f1_r - f2_r) >> ASS_FILT_SH);
   assign res_mask = ~((ASS_WORD_W'(1) << (ASS_WORD_W - RES_BITS)) - 1'b1);
   // direction bit reverses, the two zero registers give the offset
   assign ang_adj = ((reg_r[ASS_REG_DIR][ASS_DIR_BIT] ? -filt : filt)
                     - {reg_r[ASS_REG_ZERO_HI], reg_r[ASS_REG_ZERO_LO]}) & res_mask;

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         f1_r <= '0;
         f2_r <= '0;
      end else if (ce && fe_valid) begin
         f1_r <= f1_r - (f1_r >> ASS_FILT_SH) + (ASS_WORD_W+ASS_FILT_SH)'(fe_angle);
         f2_r <= f2_r - (f2_r >> ASS_FILT_SH) + (f1_r >> ASS_FILT_SH);
      end
   end

   // refresh timer, one load per microsecond while not frozen
   logic [7:0] ref_cnt_r;
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         ref_cnt_r <= '0;
         buf_r     <= '0;
      end else if (ce) begin
         if (ref_cnt_r == 8'(ASS_REFRESH_CYC - 1)) begin
            ref_cnt_r <= '0;
            if (!frozen_r && cs_s_r[1]) begin
               buf_r <= ang_adj;
            end
         end else begin
            ref_cnt_r <= ref_cnt_r + 8'h01;
         end
      end
   end

   // ==========================================
   // frame engine
   logic [ASS_WORD_W-1:0] sh_out_r;
   logic [ASS_WORD_W-1:0] sh_in_r;
   logic [4:0]            bitcnt_r;
   logic                  par_r;
   logic                  miso_r;
   logic                  rd_next_r;
   logic [4:0]            rd_addr_r;
   logic [ASS_WORD_W-1:0] head;

   // first byte with the incoming bit, left aligned as in a full word
   assign head = {sh_in_r[ASS_WORD_W-2:0], mosi_s_r[1]} << ASS_BITCNT_CMD;

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         frozen_r  <= 1'b0;
         sh_out_r  <= '0;
         sh_in_r   <= '0;
         bitcnt_r  <= '0;
         par_r     <= 1'b0;
         miso_r    <= 1'b0;
         rd_next_r <= 1'b0;
         rd_addr_r <= '0;
      end else if (ce) begin
         if (cs_fall) begin
            // frame start: freeze and preload reply
            frozen_r <= 1'b1;
            bitcnt_r <= '0;
            if (rd_next_r) begin
               sh_out_r <= {reg_r[rd_addr_r], 8'h00};
               par_r    <= par_even({reg_r[rd_addr_r], 8'h00});
               miso_r   <= reg_r[rd_addr_r][7];
            end else begin
               sh_out_r <= buf_r;
               par_r    <= par_even(buf_r);
               miso_r   <= buf_r[ASS_WORD_W-1];
            end
            rd_next_r <= 1'b0;
         end else if (cs_rise) begin
            frozen_r <= 1'b0;
         end else if (cs_l) begin
            if (sck_rise) begin
               sh_in_r  <= {sh_in_r[ASS_WORD_W-2:0], mosi_s_r[1]};
               bitcnt_r <= bitcnt_r + 5'h01;
               if (bitcnt_r == ASS_BITCNT_CMD - 5'h01) begin
                  // opcode known after first byte; a write answers with its register too
                  if (op_of(head) == ASS_OP_READ
                      || op_of(head) == ASS_OP_WRITE) begin
                     rd_next_r <= 1'b1;
                     rd_addr_r <= head[ASS_ADDR_HI:ASS_ADDR_LO];
                  end
               end
            end
            if (sck_fall && bitcnt_r != 5'h00) begin
               // mode 3 has an idle-high leading fall that counts zero
               sh_out_r <= {sh_out_r[ASS_WORD_W-2:0], 1'b0};
               miso_r   <= (bitcnt_r >= ASS_BITCNT_WORD) ? par_r
                                                         : sh_out_r[ASS_WORD_W-2];
            end
         end
      end
   end

   // ==========================================
   // write request and nvm commit
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         loaded_r  <= 1'b0;
         wr_pend_r <= 1'b0;
         wr_addr_r <= '0;
         wr_val_r  <= '0;
         nvm_cnt_r <= '0;
         for (int i = 0; i < ASS_NREG; i++) begin
            reg_r[i] <= 8'h00;
         end
      end else if (ce) begin
         if (!loaded_r) begin
            loaded_r <= 1'b1;
            for (int i = 0; i < ASS_NREG; i++) begin
               reg_r[i] <= nvm_rd_data[i];
            end
         end
         if (cs_rise && bitcnt_r >= ASS_BITCNT_WORD
             && op_of(sh_in_r) == ASS_OP_WRITE) begin
            wr_pend_r <= 1'b1;
            wr_addr_r <= sh_in_r[ASS_ADDR_HI:ASS_ADDR_LO];
            wr_val_r  <= sh_in_r[ASS_VAL_HI:0];
            nvm_cnt_r <= '0;
         end else if (wr_pend_r) begin
            if (nvm_cnt_r == 32'(NVM_CYC - 1)) begin
               wr_pend_r          <= 1'b0;
               reg_r[wr_addr_r]   <= wr_val_r;
            end else begin
               nvm_cnt_r <= nvm_cnt_r + 32'h1;
            end
         end
      end
   end

   // drive enable follows the synchronised select, registered
   logic oe_r;
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         oe_r <= 1'b0;
      end else if (ce) begin
         oe_r <= cs_l;
      end
   end

   assign lnk.miso    = miso_r;
   assign lnk.miso_oe = oe_r;

   // exported status
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         angle_out <= '0;
         busy_nvm  <= 1'b0;
      end else if (ce) begin
         angle_out <= buf_r;
         busy_nvm  <= wr_pend_r;
      end
   end
endmodule

// [test/ass_chk_sva.sv]
`timescale 1ns/1ps
// ==========================================
// wire-level checks on the serial link
module ass_chk #(
   parameter int IDLE = 150
) (
   input  wire logic mclk,
   input  wire logic arst_n,
   input  wire logic cs_n,
   input  wire logic sclk,
   input  wire logic mosi,
   input  wire logic miso,
   input  wire logic miso_oe
);
   localparam int IDLE_ANGLE = 30; // 150ns of select high at 5ns
   logic [15:0] idle_r;
   logic [4:0]  rise_r;
   logic        par_r;
   logic        sclk_r;

   default clocking @(posedge mclk); endclocking
   default disable iff (!arst_n);

   // ==========================================
   // helper counters
   // select-high time, saturating; reset counts as long idle
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         idle_r <= 16'(IDLE);
      end else if (!cs_n) begin
         idle_r <= 16'h0000;
      end else if (idle_r != 16'hffff) begin
         idle_r <= idle_r + 16'h0001;
      end
   end

   // delayed link clock for edge finding
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         sclk_r <= 1'b0;
      end else begin
         sclk_r <= sclk;
      end
   end

   // rising edges in frame and running parity of received bits
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rise_r <= 5'h00;
         par_r  <= 1'b0;
      end else if (cs_n) begin
         rise_r <= 5'h00;
         par_r  <= 1'b0;
      end else if (sclk && !sclk_r) begin
         rise_r <= rise_r + 5'h01;
         par_r  <= par_r ^ miso;
      end
   end

   // ==========================================
   // assertions
   oe_on_a: assert property (
      $fell(cs_n) |-> ##[1:4] miso_oe)
      else $error("miso_oe not raised after select fell");
   oe_off_a: assert property (
      $rose(cs_n) |-> ##[1:4] !miso_oe)
      else $error("miso_oe not dropped after select rose");
   idle_reg_a: assert property (
      $fell(cs_n) |-> idle_r >= 16'(IDLE))
      else $error("select idle shorter than register gap");
   idle_angle_a: assert property (
      $fell(cs_n) |-> idle_r >= 16'(IDLE_ANGLE))
      else $error("select idle shorter than angle gap");
   word_len_a: assert property (
      $rose(cs_n) |-> rise_r == 5'h10 || rise_r == 5'h11)
      else $error("frame not sixteen or seventeen clocks");
   mosi_hold_a: assert property (
      sclk && !cs_n && $past(!cs_n) |-> $stable(mosi))
      else $error("mosi moved while clock high");
   miso_hold_a: assert property (
      $rose(sclk) && !cs_n |-> $stable(miso) [*4])
      else $error("miso moved around rising clock");
   half_period_a: assert property (
      $changed(sclk) && !cs_n |=> $stable(sclk) [*3])
      else $error("link clock phase shorter than 20ns");
   parity_even_a: assert property (
      $rose(sclk) && !cs_n && rise_r == 5'h10 |-> !(par_r ^ miso))
      else $error("parity bit does not make ones even");
endmodule

// [test/tb_angle_sensor_spi_slave.sv]
`timescale 1ns/1ps
// ==========================================
// master and sensor joined over the link
module tb_angle_sensor_spi_slave
   import ass_pkg::*;
();
   localparam int          RES  = 14;
   localparam int          NVM  = 2000;
   localparam logic [15:0] MASK = ~((16'h0001 << (ASS_WORD_W - RES)) - 16'h0001);
   logic        mclk     = 1'b0;
   logic        fe_valid = 1'b0;
   logic        arst_n, cmd_valid, cpol, want_parity, fe_run;
   logic        cmd_ready, fe_ready, busy_nvm, rsp_parity_ok, rsp_valid;
   logic [15:0] cmd_data, fe_angle, rsp_data, angle_out;
   logic [7:0]  img [ASS_NREG];
   int          n_errors, checks;

   // clock and front-end strobe every second cycle
   always #2.5 mclk = ~mclk;
   always @(posedge mclk) fe_valid <= #1 fe_run & ~fe_valid;

   ass_if lnk ();
   ass_sensor #(.RES_BITS(RES), .NVM_CYC(NVM)) i_ass_sensor (
      .mclk(mclk), .arst_n(arst_n), .ce(1'b1), .lnk(lnk), .fe_angle(fe_angle),
      .fe_valid(fe_valid), .fe_ready(fe_ready), .nvm_rd_data(img),
      .angle_out(angle_out), .busy_nvm(busy_nvm));
   ass_master i_ass_master (
      .mclk(mclk), .arst_n(arst_n), .ce(1'b1), .lnk(lnk), .cmd_data(cmd_data),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cpol(cpol),
      .want_parity(want_parity), .rsp_data(rsp_data),
      .rsp_parity_ok(rsp_parity_ok), .rsp_valid(rsp_valid));
   ass_chk #(.IDLE(ASS_IDLE_REG_CYC)) i_ass_chk (
      .mclk(mclk), .arst_n(arst_n), .cs_n(lnk.cs_n), .sclk(lnk.sclk),
      .mosi(lnk.mosi), .miso(lnk.miso), .miso_oe(lnk.miso_oe));

   // ==========================================
   // common tasks
   task step();
      @(posedge mclk);
      #1;
   endtask

   task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         $display("wrong value %s expected %h seen %h", what, exp, seen);
         n_errors++;
      end
   endtask

   task print_verdict();
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task timeout();
      $display("wrong value wait bound expected done seen hang");
      n_errors++;
      print_verdict();
   endtask

   // offer one command, leaves valid high for a following push
   task push(input logic [15:0] c);
      int n;
      cmd_data  = c;
      cmd_valid = 1'b1;
      for (n = 0; cmd_ready !== 1'b1; n++) begin
         if (n > 4000) timeout();
         step();
      end
      step();
   endtask

   task pull(output logic [15:0] d, output logic p);
      int n;
      for (n = 0; rsp_valid !== 1'b1; n++) begin
         if (n > 8000) timeout();
         step();
      end
      d = rsp_data;
      p = rsp_parity_ok;
      step();
   endtask

   task frame(input logic [15:0] c, output logic [15:0] d, output logic p);
      push(c);
      cmd_valid = 1'b0;
      pull(d, p);
   endtask

   // ==========================================
   // scenarios
   // angle read in both clock modes, with and without parity clock
   task t_modes();
      logic [15:0] d;
      logic        p;
      int          m;
      for (m = 0; m < 4; m++) begin
         cpol        = m[1];
         want_parity = m[0];
         fe_angle    = m[1] ? 16'hb5a6 : 16'h4a5b;
         fe_run      = 1'b1;
         repeat (2000) step();
         chk("angle out", angle_out, fe_angle & MASK);
         chk("fe ready", {15'h0000, fe_ready}, 16'h0001);
         frame(16'h0000, d, p);
         chk("angle", d, fe_angle & MASK);
         if (want_parity) chk("parity ok", {15'h0000, p}, 16'h0001);
         repeat (20) step();
         chk("idle clock", {15'h0000, lnk.sclk}, {15'h0000, cpol});
      end
   endtask

   // queue until refused, then drain; every reply the held angle
   task t_fill();
      logic [15:0] d;
      logic        p;
      int          n;
      want_parity = 1'b0;
      cmd_data    = 16'h0000;
      cmd_valid   = 1'b1;
      for (n = 0; n < 12 && cmd_ready !== 1'b0; n++) step();
      cmd_valid = 1'b0;
      chk("queue refused", {15'h0000, cmd_ready}, 16'h0000);
      chk("queue depth", {15'h0000, n >= ASS_FIFO_DEPTH}, 16'h0001);
      repeat (n) begin
         pull(d, p);
         chk("repeated angle", d, fe_angle & MASK);
      end
   endtask

   // two-frame register readout at several addresses
   task t_read();
      logic [15:0] d;
      logic        p;
      logic [4:0]  al [4];
      int          i;
      al = '{5'h02, 5'h05, 5'h1b, 5'h1f};
      for (i = 0; i < 4; i++) begin
         frame({ASS_OP_READ, al[i], 8'h00}, d, p);
         frame(16'h0000, d, p);
         chk("register", {8'h00, d[15:8]}, {8'h00, img[al[i]]});
      end
   endtask

   // early acknowledge shows old value, later readback the new one
   task t_write();
      logic [15:0] d;
      logic        p;
      int          n;
      frame({ASS_OP_WRITE, 5'h05, 8'hc3}, d, p);
      frame(16'h0000, d, p);
      chk("early ack", {8'h00, d[15:8]}, {8'h00, img[5]});
      chk("commit busy", {15'h0000, busy_nvm}, 16'h0001);
      for (n = 0; busy_nvm !== 1'b0; n++) begin
         if (n > 3000) timeout();
         step();
      end
      frame({ASS_OP_READ, 5'h05, 8'h00}, d, p);
      frame(16'h0000, d, p);
      chk("written", {8'h00, d[15:8]}, 16'h00c3);
   endtask

   // reversed counting direction after a committed write
   task t_dir();
      logic [15:0] d;
      logic        p;
      int          n;
      frame({ASS_OP_WRITE, 5'h09, 8'h80}, d, p);
      frame(16'h0000, d, p);
      chk("direction ack", {8'h00, d[15:8]}, {8'h00, img[9]});
      for (n = 0; busy_nvm !== 1'b0; n++) begin
         if (n > 3000) timeout();
         step();
      end
      repeat (400) step();
      frame(16'h0000, d, p);
      chk("reversed angle", d, (16'h0000 - fe_angle) & MASK);
   endtask

   // ==========================================
   // main sequence
   initial begin
      arst_n      = 1'b0;
      cmd_valid   = 1'b0;
      cmd_data    = 16'h0000;
      cpol        = 1'b0;
      want_parity = 1'b0;
      fe_run      = 1'b0;
      fe_angle    = 16'h0000;
      n_errors    = 0;
      checks      = 0;
      // offset and direction registers stay clear so angles pass unchanged
      for (int i = 0; i < ASS_NREG; i++) begin
         img[i] = (i == 0 || i == 1 || i == 9) ? 8'h00 : 8'h5a ^ 8'(i);
      end
      repeat (16) step();
      arst_n = 1'b1;
      repeat (4) step();
      t_modes();
      t_fill();
      t_read();
      t_write();
      t_dir();
      print_verdict();
   end
endmodule
